// ==== lvd_ctrl.sv ====
// Low-voltage detector control: registers, mode logic, reset and interrupt
`timescale 1ns/1ps
`default_nettype none
module lvd_ctrl (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic lvd_reset_in,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr_byte,
  input wire logic reg_wr_bit,
  input wire logic [2:0] reg_bit_sel,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic comp_below_async,
  output logic [7:0] reg_rdata,
  output logic comp_enable,
  output logic comp_ext_sel,
  output logic [3:0] comp_level_code,
  output logic lvd_reset_req,
  output logic lvd_irq,
  output logic lvd_irq_pending_set,
  output logic lvd_reset_cause_set,
  output logic [7:0] port12_pin_dir
);
  typedef struct packed {
    logic detect_enable;
    logic action_select;
    logic source_select;
    logic [3:0] level_code;
    logic [7:0] port12_dir_reg;
    logic below_level_flag;
    logic below_prev;
    logic [7:0] rdata;
    logic reset_req;
    logic irq;
    logic pend_set;
    logic cause_set;
  } lvd_ctrl_state_t;
  lvd_ctrl_state_t state;
  lvd_ctrl_state_t next_state;
  logic below_sync;

  // Comparator level enters the clock domain here
  lvd_sync u_sync (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .async_in(comp_below_async),
    .sync_out(below_sync)
  );

  // Register writes, mode decisions and event generation
  always_comb begin
    logic [7:0] ctrl_now;
    logic [7:0] ctrl_new;
    logic below_now;
    logic ctrl_hit;
    ctrl_now = '0;
    ctrl_new = '0;
    below_now = 1'b0;
    ctrl_hit = 1'b0;
    next_state = state;
    if (clk_en) begin
      next_state.irq = 1'b0;
      next_state.pend_set = 1'b0;
      next_state.cause_set = 1'b0;
      // Flag only follows comparator while enabled, else reads 0
      below_now = state.detect_enable & below_sync;
      next_state.below_level_flag = below_now;
      next_state.below_prev = below_now;
      ctrl_now[lvd_pkg::LVD_BIT_ENABLE] = state.detect_enable;
      ctrl_now[lvd_pkg::LVD_BIT_SOURCE] = state.source_select;
      ctrl_now[lvd_pkg::LVD_BIT_ACTION] = state.action_select;
      ctrl_now[lvd_pkg::LVD_BIT_FLAG] = state.below_level_flag;
      ctrl_new = ctrl_now;
      ctrl_hit = (reg_addr == lvd_pkg::LVD_CTRL_ADDR);
      if (ctrl_hit && reg_wr_byte) begin
        ctrl_new = reg_wdata;
      end else if (ctrl_hit && reg_wr_bit) begin
        ctrl_new[reg_bit_sel] = reg_wdata[0];
      end
      if (ctrl_hit && (reg_wr_byte || reg_wr_bit)) begin
        next_state.detect_enable = ctrl_new[lvd_pkg::LVD_BIT_ENABLE];
        next_state.action_select = ctrl_new[lvd_pkg::LVD_BIT_ACTION];
        next_state.source_select = ctrl_new[lvd_pkg::LVD_BIT_SOURCE];
      end
      // Upper bits are dropped; only the code is held
      if (reg_addr == lvd_pkg::LVD_LEVEL_ADDR) begin
        if (reg_wr_byte) begin
          next_state.level_code = reg_wdata[3:0] & lvd_pkg::LVD_LEVEL_MASK;
        end else if (reg_wr_bit && !reg_bit_sel[2]) begin
          next_state.level_code[reg_bit_sel[1:0]] = reg_wdata[0];
        end
      end
      if (reg_addr == lvd_pkg::LVD_PORT12_DIR_ADDR) begin
        if (reg_wr_byte) begin
          next_state.port12_dir_reg = reg_wdata;
        end else if (reg_wr_bit) begin
          next_state.port12_dir_reg[reg_bit_sel] = reg_wdata[0];
        end
      end
      // Both crossings give a pulse in interrupt mode
      if (state.detect_enable && !state.action_select && (below_now != state.below_prev)) begin
        next_state.irq = 1'b1;
        next_state.pend_set = 1'b1;
      end
      // Disabling while below is seen as a rising crossing
      if (!state.action_select && state.below_prev && !below_now) begin
        next_state.irq = 1'b1;
        next_state.pend_set = 1'b1;
      end
      // Reset is level driven, so setting action while above does nothing
      next_state.reset_req = state.detect_enable && state.action_select && below_now;
      next_state.cause_set = next_state.reset_req;
      // Source select only picks the comparator input; threshold is fixed there
      next_state.rdata = '0;
      if (reg_rd) begin
        case (reg_addr)
          lvd_pkg::LVD_CTRL_ADDR: next_state.rdata = ctrl_now;
          lvd_pkg::LVD_LEVEL_ADDR: next_state.rdata = {4'h0, state.level_code};
          lvd_pkg::LVD_PORT12_DIR_ADDR: next_state.rdata = state.port12_dir_reg;
          default: next_state.rdata = '0;
        endcase
      end
    end
  end

  // Detector reset keeps settings; other resets clear them
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state <= '0;
      state.port12_dir_reg <= lvd_pkg::LVD_PORT12_DIR_RESET;
      if (lvd_reset_in) begin
        state.detect_enable <= next_state.detect_enable;
        state.action_select <= next_state.action_select;
        state.source_select <= next_state.source_select;
        state.level_code <= next_state.level_code;
      end
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      comp_enable <= 1'b0;
      comp_ext_sel <= 1'b0;
      comp_level_code <= '0;
      reg_rdata <= '0;
      lvd_reset_req <= 1'b0;
      lvd_irq <= 1'b0;
      lvd_irq_pending_set <= 1'b0;
      lvd_reset_cause_set <= 1'b0;
      port12_pin_dir <= lvd_pkg::LVD_PORT12_DIR_RESET;
    end else if (clk_en) begin
      comp_enable <= state.detect_enable;
      comp_ext_sel <= state.source_select;
      comp_level_code <= state.level_code;
      reg_rdata <= state.rdata;
      lvd_reset_req <= state.reset_req;
      lvd_irq <= state.irq;
      lvd_irq_pending_set <= state.pend_set;
      lvd_reset_cause_set <= state.cause_set;
      port12_pin_dir <= state.port12_dir_reg;
    end
  end
endmodule
`default_nettype wire

// ==== lvd_pkg.sv ====
// Package of constants for the low-voltage detector control block
// Contract
// - Writing 00h to control, or clearing only enable by bit write, stops detector.
// - Interrupt mode: clearing enable while below threshold raises irq and pending flag.
// - Level register keeps value on detector reset, clears to 00h otherwise.
// - Level code picks one of sixteen thresholds, 4.24 V down to 1.93 V.
// - External source compares with fixed 1.21 V threshold, ignoring level code.
// - Every reset sets port 12 direction register to ffh.
// - Direction bit 0 means output with buffer on, 1 means input.
// - Reset mode with supply source holds internal reset while supply is below threshold.
// - Reset mode with external source holds internal reset while sense is below threshold.
// - Interrupt mode raises irq on both falling and rising threshold crossings.
// - While enabled, control bit 0 shows whether voltage is below threshold.
// - No internal reset if voltage is not below when action select is set.
// - Control register holds action select at bit 1 and source select at bit 2.
// - Enable, action and source clear on any reset except a detector reset.
// - A detector reset sets reset cause bit 0.
package lvd_pkg;
  localparam logic [15:0] LVD_CTRL_ADDR = 16'hffbe;
  localparam logic [15:0] LVD_LEVEL_ADDR = 16'hffbf;
  // Port 12 direction address has no printed offset here
  localparam logic [15:0] LVD_PORT12_DIR_ADDR = 16'hff2c;
  localparam logic [7:0] LVD_CTRL_RESET = 8'h00;
  localparam logic [7:0] LVD_LEVEL_RESET = 8'h00;
  localparam logic [7:0] LVD_PORT12_DIR_RESET = 8'hff;
  localparam int LVD_BIT_FLAG = 0;
  localparam int LVD_BIT_ACTION = 1;
  localparam int LVD_BIT_SOURCE = 2;
  localparam int LVD_BIT_ENABLE = 7;
  localparam int LVD_BIT_CAUSE = 0;
  localparam int LVD_BIT_SENSE_DIR = 0;
  localparam int LVD_LEVEL_W = 4;
  localparam logic [3:0] LVD_LEVEL_MASK = 4'hf;
  localparam int LVD_STAB_TIME_NS = 10000;
  localparam int LVD_CLK_PERIOD_NS = 10;
  localparam int LVD_STAB_CYCLES = LVD_STAB_TIME_NS / LVD_CLK_PERIOD_NS;
endpackage

// ==== lvd_sync.sv ====
// Two-flop synchroniser for the asynchronous comparator output
`timescale 1ns/1ps
`default_nettype none
module lvd_sync (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic async_in,
  output logic sync_out
);
  typedef struct packed {
    logic stage1;
    logic stage2;
  } lvd_sync_state_t;
  lvd_sync_state_t state;
  lvd_sync_state_t next_state;

  // Stage one is read only by stage two
  always_comb begin
    next_state = state;
    if (clk_en) begin
      next_state.stage1 = async_in;
      next_state.stage2 = state.stage1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign sync_out = state.stage2;
endmodule
`default_nettype wire

// ==== lvd_comp_model.sv ====
// Comparator model: supply or sense input against the selected threshold
`timescale 1ns/1ps
`default_nettype none
module lvd_comp_model (
  input wire logic comp_enable,
  input wire logic comp_ext_sel,
  input wire logic [3:0] comp_level_code,
  input wire logic [3:0] supply_idx,
  input wire logic sense_low,
  output logic below
);
  // Higher code is a lower threshold; an idle comparator reads not below
  assign below = comp_enable & (comp_ext_sel ? sense_low : supply_idx > comp_level_code);
endmodule
`default_nettype wire

// ==== lvd_ctrl_asserts.sv ====
// Port assertions for the detector control block
`timescale 1ns/1ps
`default_nettype none
module lvd_ctrl_asserts (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr_byte,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic comp_enable,
  input wire logic comp_ext_sel,
  input wire logic lvd_reset_req,
  input wire logic lvd_irq,
  input wire logic lvd_irq_pending_set,
  input wire logic lvd_reset_cause_set,
  input wire logic [7:0] port12_pin_dir
);
  wire logic wc = clk_en & reg_wr_byte & (reg_addr == 16'hffbe);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  dir_after_reset_a: assert property (
    $rose(reset_n) |-> port12_pin_dir == 8'hff) else $error("direction not ff");
  enable_write_a: assert property (
    wc |=> ##1 comp_enable == $past(reg_wdata[7], 2)) else $error("enable wrong");
  source_write_a: assert property (
    wc |=> ##1 comp_ext_sel == $past(reg_wdata[2], 2)) else $error("source wrong");
  dir_write_a: assert property (
    clk_en && reg_wr_byte && reg_addr == 16'hff2c |=> ##1 port12_pin_dir == $past(reg_wdata, 2))
    else $error("direction wrong");
  cause_with_reset_a: assert property (
    lvd_reset_req |-> lvd_reset_cause_set) else $error("cause missing");
  irq_one_cycle_a: assert property (
    lvd_irq |=> !lvd_irq) else $error("irq too long");
  irq_pending_a: assert property (
    lvd_irq |-> lvd_irq_pending_set) else $error("pending missing");
  unmapped_zero_a: assert property (
    clk_en && reg_rd && !(reg_addr inside {16'hffbe, 16'hffbf, 16'hff2c}) |=> ##1 reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  cover property (lvd_irq);
  cover property ($rose(lvd_reset_req));
  cover property (wc && reg_wdata[2]);
endmodule
bind lvd_ctrl lvd_ctrl_asserts u_chk (.*);
`default_nettype wire

// ==== test_low_voltage_detect_control.sv ====
// Bench for the detector control block with a comparator model
`timescale 1ns/1ps
`default_nettype none
module test_low_voltage_detect_control;
  logic ref_clk = 0, reset_n = 0, rin = 0, wb = 0, wt = 0, rd = 0, bel, sl = 0, ce = 1;
  logic en, ext, rq, irq, cs;
  logic [15:0] ad = 0;
  logic [7:0] wd = 0, rdt, lf = 8'h45;
  logic [3:0] sup = 0, lc;
  logic [2:0] bs = 0, rp = 0;
  logic [7:0] q[$];
  int n_errors = 0, samples_checked = 0, ni = 0, n0;
  lvd_ctrl DUT (.ref_clk, .reset_n, .clk_en(ce), .lvd_reset_in(rin), .reg_addr(ad),
    .reg_wr_byte(wb), .reg_wr_bit(wt), .reg_bit_sel(bs), .reg_wdata(wd), .reg_rd(rd),
    .comp_below_async(bel), .reg_rdata(rdt), .comp_enable(en), .comp_ext_sel(ext),
    .comp_level_code(lc), .lvd_reset_req(rq), .lvd_irq(irq), .lvd_irq_pending_set(),
    .lvd_reset_cause_set(cs), .port12_pin_dir());
  lvd_comp_model CMP (.comp_enable(en), .comp_ext_sel(ext), .comp_level_code(lc),
    .supply_idx(sup), .sense_low(sl), .below(bel));
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task automatic print_verdict;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // Kind 0 byte write, 1 read with expected data, 2 bit write of d[3] to bit d[2:0]
  task automatic op(input int k, input logic [15:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    ad = a;
    wd = (k == 2) ? {7'h00, d[3]} : d;
    bs = d[2:0];
    {wb, rd, wt} = {k == 0, k == 1, k == 2};
    if (k == 1) q.push_back(d);
    @(negedge ref_clk);
    {wb, rd, wt} = 3'h0;
  endtask
  // Bounded wait for the reset request level; running out ends the run
  task automatic want(input logic v);
    for (int i = 0; i < 20 && rq !== v; i++) cyc(1);
    chk({7'h00, rq}, {7'h00, v});
    chk({7'h00, cs}, {7'h00, v});
    if (rq !== v) print_verdict;
  endtask
  // Reads answer two edges late; irq pulses are counted
  always @(posedge ref_clk) begin
    rp <= {rp[1:0], rd};
    if (irq === 1'b1) ni++;
  end
  always @(negedge ref_clk) if (rp[1]) chk(rdt, q.pop_front());
  initial forever #5 ref_clk = ~ref_clk;
  initial begin
    cyc(4);
    reset_n = 1;
    op(1, 16'hffbe, 8'h00);
    op(1, 16'hff2c, 8'hff);
    op(1, 16'hffc0, 8'h00);
    repeat (4) begin
      lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
      sup = lf[7:4];
      op(0, 16'hffbf, {4'h0, lf[3:0]});
      op(1, 16'hffbf, {4'h0, lf[3:0]});
      op(0, 16'hffbe, 8'h80);
      cyc(6);
      op(1, 16'hffbe, {7'h40, sup > lf[3:0]});
      op(0, 16'hffbe, 8'h00);
    end
    // Interrupt mode: both crossings, sense source, stop while below
    sup = 0;
    op(0, 16'hffbf, 8'h08);
    op(0, 16'hffbe, 8'h80);
    cyc(6);
    n0 = ni;
    sup = 4'hf;
    cyc(6);
    sup = 4'h0;
    cyc(6);
    op(0, 16'hffbe, 8'h84);
    cyc(2);
    sup = 4'hf;
    cyc(6);
    sl = 1;
    cyc(6);
    op(1, 16'hffbe, 8'h85);
    op(2, 16'hffbe, 8'h07);
    cyc(6);
    chk(8'(ni - n0), 8'h04);
    // Reset mode on supply then sense input
    {sl, sup} = 5'h00;
    op(0, 16'hffbe, 8'h80);
    cyc(6);
    op(1, 16'hffbe, 8'h80);
    op(0, 16'hffbe, 8'h82);
    cyc(6);
    chk({7'h00, rq}, 8'h00);
    sup = 4'hf;
    want(1);
    sup = 4'h0;
    want(0);
    op(0, 16'hffbe, 8'h86);
    cyc(2);
    sl = 1;
    want(1);
    op(0, 16'hff2c, 8'hfe);
    op(1, 16'hff2c, 8'hfe);
    op(2, 16'hff2c, 8'h08);
    op(1, 16'hff2c, 8'hff);
    cyc(2);
    // Detector reset keeps settings, any other reset clears them
    {reset_n, rin} = 2'b01;
    cyc(2);
    {reset_n, rin} = 2'b10;
    // Comparator path refills after reset before the flag shows below
    cyc(6);
    op(1, 16'hffbe, 8'h87);
    op(1, 16'hffbf, 8'h08);
    sl = 0;
    want(0);
    op(2, 16'hffbe, 8'h01);
    op(2, 16'hffbe, 8'h07);
    op(1, 16'hffbe, 8'h04);
    op(0, 16'hff2c, 8'h00);
    reset_n = 0;
    cyc(2);
    reset_n = 1;
    op(1, 16'hffbe, 8'h00);
    op(1, 16'hffbf, 8'h00);
    op(1, 16'hff2c, 8'hff);
    cyc(2);
    // Frozen clock enable drops a level write
    ce = 0;
    op(0, 16'hffbf, 8'h03);
    ce = 1;
    op(1, 16'hffbf, 8'h00);
    cyc(4);
    print_verdict;
  end
endmodule
`default_nettype wire
